// *** hw/cp_resp_defs.vh ***
`ifndef CP_RESP_DEFS_VH
`define CP_RESP_DEFS_VH

// Response word layout
`define RESP_W 16
`define RESP_BIT_CA 15
`define RESP_BIT_PC 4
`define RESP_BIT_IA 8
`define RESP_BIT_PF 1
`define RESP_BIT_TF 0
// Primitive type field, bits 12..9; bit 8 and 7..0 checked separately
`define RESP_TYPE_HI 12
`define RESP_TYPE_LO 9
// Type field values; the field width is four bits
`define RESP_TYPE_NULL 4'h0
`define RESP_TYPE_BUSY 4'h2

// Register map of the plain register port
`define REG_AW 4
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_LAST_RESP 4'h8
`define REG_COUNT 4'hC

// Control field positions
`define CTRL_BIT_ENABLE 0
`define CTRL_RST_VAL 8'h01

// Action codes reported in bits 10..8 of the status register
`define ACT_W 3
`define ACT_NONE 3'h0
`define ACT_REREAD 3'h1
`define ACT_IRQ_REREAD 3'h2
`define ACT_IRQ_RESTART 3'h3
`define ACT_DONE 3'h4
`define ACT_TRACE 3'h5
`define ACT_UNKNOWN 3'h6

`endif

// *** hw/resp_decode.v ***
`timescale 1ns/100ps
`include "cp_resp_defs.vh"

// Pure decode of a response word into its flags
module resp_decode (
    input wire [`RESP_W-1:0] word_in,
    output wire is_null_out,
    output wire is_busy_out,
    output wire come_again_flag_out,
    output wire pass_counter_flag_out,
    output wire interrupts_allowed_flag_out,
    output wire processing_finished_flag_out,
    output wire condition_result_flag_out
);
    wire [3:0] kind;
    assign kind = word_in[`RESP_TYPE_HI:`RESP_TYPE_LO];
    // Bits 15, 8, 1 and 0 are not part of the type for the null primitive
    // Bit 4 is the pass-counter flag, so a null word may carry it
    assign is_null_out = (kind == `RESP_TYPE_NULL) && (word_in[7:5] == 3'h0)
        && (word_in[3:2] == 2'h0) && (word_in[14:13] == 2'h0);
    assign is_busy_out = (kind == `RESP_TYPE_BUSY) && (word_in[8:5] == 4'h0)
        && (word_in[3:0] == 4'h0);
    assign come_again_flag_out = word_in[`RESP_BIT_CA];
    assign pass_counter_flag_out = word_in[`RESP_BIT_PC];
    assign interrupts_allowed_flag_out = word_in[`RESP_BIT_IA];
    assign processing_finished_flag_out = word_in[`RESP_BIT_PF];
    assign condition_result_flag_out = word_in[`RESP_BIT_TF];
endmodule // resp_decode

// *** hw/sync3.v ***
`timescale 1ns/100ps

// Three-stage synchroniser; change accepted when stages two and three agree
module sync3 (
    input wire ref_clk_in,
    input wire rst_in,
    input wire d_in,
    output wire q_out
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg q_ff;
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                q_ff <= s3_ff;
            end
        end
    end
    assign q_out = q_ff;
endmodule // sync3

// *** hw/coproc_busy_null_primitive_handler.v ***
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "cp_resp_defs.vh"

module coproc_busy_null_primitive_handler #(
    parameter ADDR_W = 32
) (
    input wire ref_clk_in,
    input wire rst_in,
    // Instruction start from the core
    input wire start_in,
    input wire conditional_in,
    input wire from_breakpoint_in,
    input wire [ADDR_W-1:0] program_counter_in,
    // Core status levels
    input wire trace_pending_in,
    input wire irq_pending_in,
    input wire irq_done_in,
    // Response register access toward the coprocessor
    output wire resp_read_out,
    input wire resp_valid_in,
    input wire [`RESP_W-1:0] coprocessor_interface_register_in,
    output reg pc_write_out,
    output reg [ADDR_W-1:0] pc_data_out,
    // Decisions toward the core
    output reg irq_service_out,
    output reg irq_midinstr_frame_out,
    output reg restart_out,
    output reg repeat_bkpt_ack_out,
    output reg done_out,
    output reg cond_true_out,
    output reg trace_out,
    output reg other_prim_out,
    output reg [`RESP_W-1:0] other_word_out,
    // Plain register port
    input wire [`REG_AW-1:0] reg_addr_in,
    input wire [31:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [31:0] reg_rdata_out
);

////////////////////////////////////////////////////////////////////////////////
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_READ = 6'b000010;
    localparam [5:0] S_EVAL = 6'b000100;
    localparam [5:0] S_IRQ = 6'b001000;
    localparam [5:0] S_PASS = 6'b010000;
    localparam [5:0] S_END = 6'b100000;

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg [`RESP_W-1:0] resp_ff;
    reg [`RESP_W-1:0] nxt_resp;
    reg cond_ff;
    reg bkpt_ff;
    reg restart_after_irq_ff;
    reg nxt_restart_after_irq;
    reg [7:0] ctrl_ff;
    reg [15:0] count_ff;
    reg [`ACT_W-1:0] act_ff;
    reg [`ACT_W-1:0] nxt_act;
    reg nxt_pc_write;
    reg nxt_irq_service;
    reg nxt_midframe;
    reg nxt_restart;
    reg nxt_bkpt;
    reg nxt_done;
    reg nxt_true;
    reg nxt_trace;
    reg nxt_other;

    wire is_null;
    wire is_busy;
    wire ca;
    wire pcf;
    wire ia;
    wire pf;
    wire tf;
    wire enable;
    wire irq_done_s;
    wire trace_s;
    wire resp_taken;

    // Disabled block ignores start but finishes a running dialogue
    assign enable = ctrl_ff[`CTRL_BIT_ENABLE];
    assign resp_taken = (state_ff == S_READ) && resp_valid_in;

    resp_decode u_dec (
        .word_in(resp_ff),
        .is_null_out(is_null),
        .is_busy_out(is_busy),
        .come_again_flag_out(ca),
        .pass_counter_flag_out(pcf),
        .interrupts_allowed_flag_out(ia),
        .processing_finished_flag_out(pf),
        .condition_result_flag_out(tf)
    );

    // Interrupt acknowledge from the exception unit is asynchronous here
    sync3 u_irq_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in(irq_done_in),
        .q_out(irq_done_s)
    );
    // Trace bit may come from another domain too
    sync3 u_trace_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .d_in(trace_pending_in),
        .q_out(trace_s)
    );

    // one read per word relies on holding
    assign resp_read_out = (state_ff == S_READ);

////////////////////////////////////////////////////////////////////////////////
    always @* begin
        nxt_state = state_ff;
        nxt_resp = resp_ff;
        nxt_act = act_ff;
        nxt_restart_after_irq = restart_after_irq_ff;
        nxt_pc_write = 1'b0;
        nxt_irq_service = 1'b0;
        nxt_midframe = 1'b0;
        nxt_restart = 1'b0;
        nxt_bkpt = 1'b0;
        nxt_done = 1'b0;
        nxt_true = 1'b0;
        nxt_trace = 1'b0;
        nxt_other = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start_in && enable) begin
                    nxt_state = S_READ;
                end
            end
            S_READ: begin
                if (resp_valid_in) begin
                    nxt_resp = coprocessor_interface_register_in;
                    nxt_state = S_PASS;
                end
            end
            S_PASS: begin
                if (is_busy || is_null) begin
                    if (resp_ff[`RESP_BIT_PC]) begin
                        nxt_pc_write = 1'b1;
                        nxt_resp = resp_ff & ~(16'h0001 << `RESP_BIT_PC);
                    end
                end else if (pcf) begin
                    // Unknown primitive still passes the counter first
                    nxt_pc_write = 1'b1;
                end
                nxt_state = S_EVAL;
            end
            S_EVAL: begin
                // Default is a reread; every ending branch overrides it
                nxt_state = S_READ;
                if (is_busy) begin
                    // busy assumed before any visible change
                    nxt_act = `ACT_IRQ_RESTART;
                    nxt_restart_after_irq = 1'b1;
                    if (irq_pending_in) begin
                        nxt_irq_service = 1'b1;
                        nxt_state = S_IRQ;
                    end else begin
                        nxt_restart = 1'b1;
                        nxt_state = S_IDLE;
                    end
                end else if (!is_null) begin
                    nxt_act = `ACT_UNKNOWN;
                    nxt_other = 1'b1;
                    nxt_state = S_IDLE;
                end else if (ca) begin
                    nxt_restart_after_irq = 1'b0;
                    if (ia && irq_pending_in) begin
                        nxt_act = `ACT_IRQ_REREAD;
                        nxt_irq_service = 1'b1;
                        nxt_midframe = 1'b1;
                        nxt_state = S_IRQ;
                    end else begin
                        nxt_act = `ACT_REREAD;
                    end
                end else if (cond_ff) begin
                    nxt_act = `ACT_DONE;
                    nxt_done = 1'b1;
                    nxt_true = tf;
                    nxt_state = S_END;
                end else if (pf) begin
                    nxt_act = `ACT_DONE;
                    nxt_done = 1'b1;
                    nxt_trace = trace_s;
                    nxt_state = S_END;
                end else if (trace_s) begin
                    nxt_restart_after_irq = 1'b0;
                    nxt_act = `ACT_REREAD;
                    if (ia && irq_pending_in) begin
                        nxt_act = `ACT_IRQ_REREAD;
                        nxt_irq_service = 1'b1;
                        nxt_midframe = 1'b1;
                        nxt_state = S_IRQ;
                    end
                end else begin
                    nxt_act = `ACT_DONE;
                    nxt_done = 1'b1;
                    nxt_state = S_END;
                end
            end
            S_IRQ: begin
                // Level wait; a done still high from before lets this pass early
                if (irq_done_s) begin
                    if (restart_after_irq_ff) begin
                        nxt_restart = 1'b1;
                        nxt_bkpt = bkpt_ff;
                        nxt_state = S_IDLE;
                    end else begin
                        nxt_state = S_READ;
                    end
                end
            end
            S_END: begin
                nxt_state = S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= S_IDLE;
            resp_ff <= 16'h0000;
            cond_ff <= 1'b0;
            bkpt_ff <= 1'b0;
            restart_after_irq_ff <= 1'b0;
            act_ff <= `ACT_NONE;
            pc_write_out <= 1'b0;
            pc_data_out <= {ADDR_W{1'b0}};
            irq_service_out <= 1'b0;
            irq_midinstr_frame_out <= 1'b0;
            restart_out <= 1'b0;
            repeat_bkpt_ack_out <= 1'b0;
            done_out <= 1'b0;
            cond_true_out <= 1'b0;
            trace_out <= 1'b0;
            other_prim_out <= 1'b0;
            other_word_out <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            resp_ff <= nxt_resp;
            act_ff <= nxt_act;
            restart_after_irq_ff <= nxt_restart_after_irq;
            if (state_ff == S_IDLE && start_in && enable) begin
                cond_ff <= conditional_in;
                bkpt_ff <= from_breakpoint_in;
            end
            pc_write_out <= nxt_pc_write;
            if (nxt_pc_write) begin
                pc_data_out <= program_counter_in;
            end
            irq_service_out <= nxt_irq_service;
            irq_midinstr_frame_out <= nxt_midframe;
            restart_out <= nxt_restart;
            repeat_bkpt_ack_out <= nxt_bkpt;
            done_out <= nxt_done;
            cond_true_out <= nxt_true;
            trace_out <= nxt_trace;
            other_prim_out <= nxt_other;
            if (nxt_other) begin
                // Kept for the core's fault handler
                other_word_out <= resp_ff;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Count of responses read; wraps silently
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_ff <= `CTRL_RST_VAL;
            count_ff <= 16'h0000;
            reg_rdata_out <= 32'h00000000;
        end else begin
            if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
                ctrl_ff <= reg_wdata_in[7:0];
            end
            // Clear and a word taken in one cycle: the word still counts
            if (reg_wr_in && reg_addr_in == `REG_COUNT) begin
                count_ff <= {15'h0000, resp_taken};
            end else if (resp_taken) begin
                count_ff <= count_ff + 16'h0001;
            end
            reg_rdata_out <= 32'h00000000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `REG_CTRL: reg_rdata_out <= {24'h000000, ctrl_ff};
                    `REG_STATUS: reg_rdata_out <= {21'h000000, act_ff, 2'h0, state_ff};
                    `REG_LAST_RESP: reg_rdata_out <= {16'h0000, resp_ff};
                    `REG_COUNT: reg_rdata_out <= {16'h0000, count_ff};
                    default: reg_rdata_out <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // coproc_busy_null_primitive_handler

// *** verification/resp_chk_sva.sv ***
`timescale 1ns/100ps
module resp_chk #(parameter ADDR_W = 32) (
    input wire ref_clk_in,
    input wire rst_in,
    input wire conditional_in,
    input wire irq_pending_in,
    input wire [ADDR_W-1:0] program_counter_in,
    input wire resp_read_out,
    input wire resp_valid_in,
    input wire [15:0] coprocessor_interface_register_in,
    input wire pc_write_out,
    input wire [ADDR_W-1:0] pc_data_out,
    input wire irq_service_out,
    input wire irq_midinstr_frame_out,
    input wire restart_out,
    input wire repeat_bkpt_ack_out,
    input wire done_out,
    input wire cond_true_out,
    input wire trace_out
);
    // Pass-counter bit masked off
    wire [15:0] w = coprocessor_interface_register_in & 16'hFFEF;
    wire tk = resp_read_out & resp_valid_in;
    wire nul = tk && ((w & 16'h7EEC) == 16'h0000);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    a_pc_passed: assert property (pc_write_out |-> pc_data_out == program_counter_in)
        else $error("pc value not passed");
    a_busy_restart: assert property (tk && w == 16'h0400 && !irq_pending_in |-> ##[2:6] restart_out)
        else $error("busy without restart");
    a_busy_irq: assert property (tk && w == 16'h0400 && irq_pending_in |->
        ##[2:6] (irq_service_out && !irq_midinstr_frame_out)) else $error("busy irq frame");
    a_bkpt_restart: assert property (repeat_bkpt_ack_out |-> restart_out)
        else $error("bkpt repeat alone");
    a_ca_reread: assert property (nul && w[15] && !w[8] |=>
        !irq_service_out throughout (##[1:7] resp_read_out)) else $error("no plain reread");
    a_ca_irq: assert property (nul && w[15] && w[8] && irq_pending_in |->
        ##[2:6] (irq_service_out && irq_midinstr_frame_out)) else $error("no mid irq");
    a_cond_true: assert property (nul && !w[15] && conditional_in && w[0] |->
        ##[2:6] (done_out && cond_true_out)) else $error("cond result lost");
    a_gen_done: assert property (nul && !w[15] && w[1] && !conditional_in |-> ##[2:6] done_out)
        else $error("general not done");
    a_trace_end: assert property (trace_out |-> done_out && !conditional_in)
        else $error("trace without done");
    a_irq_pending: assert property (irq_service_out |-> irq_pending_in)
        else $error("irq without pending");
endmodule // resp_chk

bind coproc_busy_null_primitive_handler resp_chk #(.ADDR_W(ADDR_W)) chk (.ref_clk_in, .rst_in,
    .conditional_in, .irq_pending_in, .program_counter_in, .resp_read_out, .resp_valid_in,
    .coprocessor_interface_register_in, .pc_write_out, .pc_data_out, .irq_service_out,
    .irq_midinstr_frame_out, .restart_out, .repeat_bkpt_ack_out, .done_out, .cond_true_out,
    .trace_out);

// *** verification/cop_model.sv ***
`timescale 1ns/100ps
module cop_model (
    input wire ref_clk_in,
    input wire rst_in,
    input wire slow_in,
    input wire resp_read_in,
    output logic resp_valid_out,
    output logic [15:0] word_out
);
    logic [15:0] q[$];
    integer pseed = 38;
    task push(input logic [15:0] wd);
        q.push_back(wd);
    endtask
    ////////////////////////////////////////
    // sixteen-bit word held until read
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            resp_valid_out <= 1'b0;
            word_out <= 16'h5A5A;
        end else if (resp_valid_out && resp_read_in) begin
            // Stale word inverted so nothing leans on it
            resp_valid_out <= 1'b0;
            word_out <= ~word_out;
        end else if (!resp_valid_out && q.size() > 0 && (!slow_in || ($random(pseed) & 3) == 0)) begin
            word_out <= q.pop_front();
            resp_valid_out <= 1'b1;
        end
    end
endmodule // cop_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    logic ref_clk_in, rst_in, start_in, conditional_in, from_breakpoint_in, slow;
    logic trace_pending_in, irq_pending_in, irq_done_in, resp_read_out, resp_valid_in;
    logic pc_write_out, irq_service_out, irq_midinstr_frame_out, restart_out, reg_wr_in;
    logic repeat_bkpt_ack_out, done_out, cond_true_out, trace_out, other_prim_out, reg_rd_in;
    logic [3:0] reg_addr_in;
    logic [15:0] coprocessor_interface_register, other_word_out;
    logic [31:0] program_counter_in, pc_data_out, reg_wdata_in, reg_rdata_out;
    logic [8:0] got[$], expq[$];
    logic [15:0] wq[$];
    integer seed = 38, error_cnt = 0, compares = 0, k;
    wire [8:0] ev = {pc_write_out, irq_service_out, irq_midinstr_frame_out, restart_out,
        repeat_bkpt_ack_out, done_out, cond_true_out, trace_out, other_prim_out};

    coproc_busy_null_primitive_handler dut (.ref_clk_in, .rst_in, .start_in, .conditional_in,
        .from_breakpoint_in, .program_counter_in, .trace_pending_in, .irq_pending_in,
        .irq_done_in, .resp_read_out, .resp_valid_in, .coprocessor_interface_register_in(coprocessor_interface_register),
        .pc_write_out, .pc_data_out, .irq_service_out, .irq_midinstr_frame_out, .restart_out,
        .repeat_bkpt_ack_out, .done_out, .cond_true_out, .trace_out, .other_prim_out,
        .other_word_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
    cop_model cop (.ref_clk_in, .rst_in, .slow_in(slow), .resp_read_in(resp_read_out),
        .resp_valid_out(resp_valid_in), .word_out(coprocessor_interface_register));

    initial begin
        ref_clk_in = 0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    ////////////////////////////////////////
    task chk_ev(input logic [8:0] g, input logic [8:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task chk_word(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task results;
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1;
        @(posedge ref_clk_in);
        reg_wr_in <= 0;
    endtask
    task rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge ref_clk_in);
        reg_rd_in <= 0;
        #1 chk_word(reg_rdata_out, e);
    endtask
    // Model: expected pulse vectors per word, stopping where the dialogue ends
    task run(input logic c, input logic b, input logic t, input logic i);
        logic [15:0] w;
        logic fin;
        integer m;
        conditional_in <= c;
        from_breakpoint_in <= b;
        trace_pending_in <= t;
        irq_pending_in <= i;
        program_counter_in <= $random(seed);
        // Levels need time through the synchronisers
        repeat (8) @(posedge ref_clk_in);
        expq = {};
        got = {};
        fin = 0;
        foreach (wq[n]) if (!fin) begin
            w = wq[n];
            cop.push(w);
            if (w[4]) expq.push_back(9'h100);
            w[4] = 0;
            if (w == 16'h0400) begin
                if (i) expq.push_back(9'h080);
                expq.push_back({4'h1, b & i, 4'h0});
                fin = 1;
            end else if ((w & 16'h7EEC) != 0) begin
                expq.push_back(9'h001);
                fin = 1;
            end else if (w[15] || (t && !c && !w[1])) begin
                if (w[8] && i) expq.push_back(9'h0C0);
            end else begin
                expq.push_back({6'h01, c & w[0], t & !c, 1'b0});
                fin = 1;
            end
        end
        start_in <= 1;
        @(posedge ref_clk_in);
        start_in <= 0;
        m = 0;
        while (got.size() < expq.size() && m < 400) begin
            @(posedge ref_clk_in);
            m++;
        end
        repeat (10) @(posedge ref_clk_in);
        chk_word(got.size(), expq.size());
        foreach (expq[n]) chk_ev(n < got.size() ? got[n] : 9'h1FF, expq[n]);
    endtask
    ////////////////////////////////////////
    always @(negedge ref_clk_in) if (!rst_in) begin
        if (ev !== 9'h000) got.push_back(ev);
        if (pc_write_out) chk_word(pc_data_out, program_counter_in);
    end
    // Core side finishes interrupt service a little later
    always @(posedge ref_clk_in) if (irq_service_out === 1'b1) begin
        repeat (2) @(posedge ref_clk_in);
        irq_done_in <= 1;
        repeat (6) @(posedge ref_clk_in);
        irq_done_in <= 0;
    end
    initial begin
        #100000;
        error_cnt++;
        results;
    end
    initial begin
        rst_in = 1;
        {start_in, conditional_in, from_breakpoint_in, slow, reg_wr_in, reg_rd_in} = '0;
        {trace_pending_in, irq_pending_in, irq_done_in} = '0;
        program_counter_in = 0;
        reg_addr_in = 0;
        reg_wdata_in = 0;
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 0;
        rdc(4'h0, 32'h1);
        rdc(4'h2, 32'h0);
        wr(4'hC, 32'h0);
        wq = '{16'h0012};
        run(0, 0, 0, 0);
        rdc(4'hC, 32'h1);
        rdc(4'h8, 32'h2);
        wq = '{16'h8000, 16'h8100, 16'h0002};
        run(0, 0, 0, 1);
        wq = '{16'h8110, 16'h0001};
        run(1, 0, 0, 1);
        wq = '{16'h0400};
        run(0, 1, 0, 0);
        wq = '{16'h0410};
        run(1, 1, 0, 1);
        slow = 1;
        wq = '{16'h0100, 16'h0000, 16'h0002};
        run(0, 0, 1, 1);
        wq = '{16'h1C00};
        run(0, 0, 0, 0);
        chk_word(other_word_out, 32'h1C00);
        for (k = 0; k < 8; k++) begin
            wq = '{$random(seed) & 16'h0113};
            run(k[0], 0, 0, 1);
        end
        wr(4'h0, 32'h0);
        wq = '{};
        run(0, 0, 0, 0);
        rdc(4'h4, 32'h00000401);
        wr(4'h0, 32'h1);
        results;
    end
endmodule // tb_top
